// *** verilog/svpi_top.sv ***
// Shared-vector interrupt group: flags, enables, service entry, registers
// Operation
// RULE1 - Shared request raised only by time-base, tick and timer-1 overflow.
// RULE2 - Shared interrupt taken only with global, group enables and shared flag set.
// RULE3 - Enabled, stack not full, contributor fires: call vector 018H.
// RULE4 - On service entry clear shared flag and global enable.
// RULE5 - Software clears contributor flags; hardware leaves them set on service.
// RULE6 - Tick interrupt needs global, tick and group enables all set.
// RULE7 - Tick flag set and enabled calls vector 18H; service clears shared only.
// RULE8 - Tick divides source clock by 2^8 to 2^15 via three-bit ratio.
// RULE9 - Source clock is low-speed oscillator or system clock over four.
// RULE10 - Time-base interrupt needs global, time-base and group enables set.
// RULE11 - Time-base overflow sets its flag, calls shared vector, stays set.
// RULE12 - Time-base period fixed by build option, 2^12 to 2^15 cycles.
// RULE13 - Enables only block service; set flags persist until serviced or cleared.
// RULE14 - Every source in the group can wake the processor from power-down.
// RULE15 - On entry only the program counter is pushed.
// RULE16 - Service routines should avoid subroutine calls near a full stack.
// RULE17 - Requests between two T2 edges are sampled on the later edge.
// RULE18 - No acknowledge while the stack is full.
// RULE19 - Shared flag set when an individually enabled contributor flag sets.
`timescale 1ns/10ps
module svpi_top
  import svpi_pkg::*;
#(
  parameter bit         FS_SEL_LOW_SPEED_INTERNAL_OSC = 1'b1,
  parameter logic [1:0] TB_SEL      = 2'h0
)(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic                   i_low_speed_internal_osc_pulse,
  input  wire logic                   i_timer1_overflow,
  input  wire logic                   i_t2_strobe,
  input  wire logic                   i_stack_full,
  input  wire logic                   i_higher_pending,
  output logic                        o_call,
  output logic [7:0]                  o_vector,
  output logic                        o_push_pc,
  output logic                        o_wake,
  output logic                        o_irq,
  input  wire logic                   i_s_axi_awvalid,
  input  wire logic [SVPI_ADDR_W-1:0] i_s_axi_awaddr,
  output logic                        o_s_axi_awready,
  input  wire logic                   i_s_axi_wvalid,
  input  wire logic [31:0]            i_s_axi_wdata,
  input  wire logic [3:0]             i_s_axi_wstrb,
  output logic                        o_s_axi_wready,
  output logic                        o_s_axi_bvalid,
  output logic [1:0]                  o_s_axi_bresp,
  input  wire logic                   i_s_axi_bready,
  input  wire logic                   i_s_axi_arvalid,
  input  wire logic [SVPI_ADDR_W-1:0] i_s_axi_araddr,
  output logic                        o_s_axi_arready,
  output logic                        o_s_axi_rvalid,
  output logic [31:0]                 o_s_axi_rdata,
  output logic [1:0]                  o_s_axi_rresp,
  input  wire logic                   i_s_axi_rready
);
  import svpi_pkg::*;

  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic                  global_irq_enable;
    logic                  shared_group_enable;
    logic                  tick_irq_enable;
    logic                  timebase_irq_enable;
    logic                  timer1_irq_enable;
    logic                  shared_request_flag;
    logic                  tick_request_flag;
    logic                  timebase_request_flag;
    logic                  timer1_request_flag;
    logic [2:0]            tick_ratio;
    logic [SVPI_EVT_N-1:0] irq_status;
    logic [SVPI_EVT_N-1:0] irq_mask;
    logic                  irq;
    logic                  call;
    logic                  push_pc;
    logic                  wake;
    logic [7:0]            vector;
  } svpi_core_st_t;

  svpi_core_st_t         r;
  svpi_core_st_t         n;
  svpi_reg_if            bus ();
  logic                  tick_evt;
  logic                  tb_evt;
  logic                  we;
  logic                  take;
  logic                  contrib_set;
  logic [SVPI_EVT_N-1:0] evt;
  logic [7:0]            wd;

  // ***********************************************************
  // Sub-blocks
  // ***********************************************************
  svpi_periodic_div #(
    .FS_SEL_LOW_SPEED_INTERNAL_OSC (FS_SEL_LOW_SPEED_INTERNAL_OSC),
    .TB_SEL      (TB_SEL)
  ) u_div (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_low_speed_internal_osc_pulse (i_low_speed_internal_osc_pulse),
    .i_ratio      (r.tick_ratio),
    .o_tick_evt   (tick_evt),
    .o_tb_evt     (tb_evt)
  );

  svpi_axi_slave u_axi (
    .i_clk_sys (i_clk_sys),
    .i_reset   (i_reset),
    .i_awvalid (i_s_axi_awvalid),
    .i_awaddr  (i_s_axi_awaddr),
    .o_awready (o_s_axi_awready),
    .i_wvalid  (i_s_axi_wvalid),
    .i_wdata   (i_s_axi_wdata),
    .i_wstrb   (i_s_axi_wstrb),
    .o_wready  (o_s_axi_wready),
    .o_bvalid  (o_s_axi_bvalid),
    .o_bresp   (o_s_axi_bresp),
    .i_bready  (i_s_axi_bready),
    .i_arvalid (i_s_axi_arvalid),
    .i_araddr  (i_s_axi_araddr),
    .o_arready (o_s_axi_arready),
    .o_rvalid  (o_s_axi_rvalid),
    .o_rdata   (o_s_axi_rdata),
    .o_rresp   (o_s_axi_rresp),
    .i_rready  (i_s_axi_rready),
    .bus       (bus.slave)
  );

  // ***********************************************************
  // Address decode and read mux
  // ***********************************************************
  always_comb
  begin
    unique case (bus.wr_addr)
      SVPI_OFF_CTRL, SVPI_OFF_FLAGS, SVPI_OFF_TICK,
      SVPI_OFF_ISTAT, SVPI_OFF_IMASK: bus.wr_hit = 1'b1;
      default:                        bus.wr_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    bus.rd_hit  = 1'b1;
    bus.rd_data = 8'h00;
    unique case (bus.rd_addr)
      SVPI_OFF_CTRL:
      begin
        bus.rd_data[SVPI_CTRL_GIE]  = r.global_irq_enable;
        bus.rd_data[SVPI_CTRL_GRP]  = r.shared_group_enable;
        bus.rd_data[SVPI_CTRL_TICK] = r.tick_irq_enable;
        bus.rd_data[SVPI_CTRL_TB]   = r.timebase_irq_enable;
        bus.rd_data[SVPI_CTRL_T1]   = r.timer1_irq_enable;
      end
      SVPI_OFF_FLAGS:
      begin
        bus.rd_data[SVPI_FLG_SHARED] = r.shared_request_flag;
        bus.rd_data[SVPI_FLG_TICK]   = r.tick_request_flag;
        bus.rd_data[SVPI_FLG_TB]     = r.timebase_request_flag;
        bus.rd_data[SVPI_FLG_T1]     = r.timer1_request_flag;
      end
      SVPI_OFF_TICK:  bus.rd_data[2:0] = r.tick_ratio;
      SVPI_OFF_ISTAT: bus.rd_data[SVPI_EVT_N-1:0] = r.irq_status;
      SVPI_OFF_IMASK: bus.rd_data[SVPI_EVT_N-1:0] = r.irq_mask;
      default:        bus.rd_hit = 1'b0;
    endcase
  end

  // ***********************************************************
  // Request and service logic
  // ***********************************************************
  assign we = bus.wr_en & bus.wr_be0 & bus.wr_hit;
  assign wd = bus.wr_data;

  // Only the three contributors can raise the shared request
  assign contrib_set = (tick_evt & r.tick_irq_enable)              // [RULE6] [RULE19]
                     | (tb_evt & r.timebase_irq_enable)            // [RULE10] [RULE19]
                     | (i_timer1_overflow & r.timer1_irq_enable);  // [RULE1] [RULE19]

  // Sampled on the T2 strobe; a full stack or a higher source defers it
  assign take = i_t2_strobe                                        // [RULE17]
              & r.global_irq_enable & r.shared_group_enable        // [RULE2]
              & r.shared_request_flag
              & ~i_stack_full                                      // [RULE18]
              & ~i_higher_pending;

  assign evt = {take, i_timer1_overflow, tb_evt, tick_evt};

  always_comb
  begin
    n         = r;
    n.call    = take;                                              // [RULE3] [RULE7]
    n.push_pc = take;                                              // [RULE15]
    n.vector  = SVPI_VECTOR;                                       // [RULE3]
    if (we && (bus.wr_addr == SVPI_OFF_CTRL))
    begin
      n.global_irq_enable   = wd[SVPI_CTRL_GIE];
      n.shared_group_enable = wd[SVPI_CTRL_GRP];
      n.tick_irq_enable     = wd[SVPI_CTRL_TICK];
      n.timebase_irq_enable = wd[SVPI_CTRL_TB];
      n.timer1_irq_enable   = wd[SVPI_CTRL_T1];
    end
    if (we && (bus.wr_addr == SVPI_OFF_TICK))
    begin
      n.tick_ratio = wd[2:0];                                      // [RULE8]
    end
    if (we && (bus.wr_addr == SVPI_OFF_IMASK))
    begin
      n.irq_mask = wd[SVPI_EVT_N-1:0];
    end
    // Write one to clear; only software or service clears a flag
    if (we && (bus.wr_addr == SVPI_OFF_FLAGS))
    begin
      if (wd[SVPI_FLG_SHARED])
      begin
        n.shared_request_flag = 1'b0;
      end
      if (wd[SVPI_FLG_TICK])
      begin
        n.tick_request_flag = 1'b0;                                // [RULE5] [RULE13]
      end
      if (wd[SVPI_FLG_TB])
      begin
        n.timebase_request_flag = 1'b0;                            // [RULE5] [RULE13]
      end
      if (wd[SVPI_FLG_T1])
      begin
        n.timer1_request_flag = 1'b0;                              // [RULE5] [RULE13]
      end
    end
    if (we && (bus.wr_addr == SVPI_OFF_ISTAT))
    begin
      n.irq_status = r.irq_status & ~wd[SVPI_EVT_N-1:0];
    end
    // Service entry touches only the shared flag and the global enable
    if (take)
    begin
      n.shared_request_flag = 1'b0;                                // [RULE4] [RULE7] [RULE11]
      n.global_irq_enable   = 1'b0;                                // [RULE4]
    end
    // Sets come last so an event never loses to a clear
    if (tick_evt)
    begin
      n.tick_request_flag = 1'b1;                                  // [RULE13]
    end
    if (tb_evt)
    begin
      n.timebase_request_flag = 1'b1;                              // [RULE11]
    end
    if (i_timer1_overflow)
    begin
      n.timer1_request_flag = 1'b1;
    end
    if (contrib_set)
    begin
      n.shared_request_flag = 1'b1;                                // [RULE19]
    end
    n.irq_status = n.irq_status | evt;
    n.irq        = |(n.irq_status & n.irq_mask);
    // Wake ignores the global enable, as power-down has no sequencer running
    n.wake = (n.tick_request_flag & n.tick_irq_enable)             // [RULE14]
           | (n.timebase_request_flag & n.timebase_irq_enable)
           | (n.timer1_request_flag & n.timer1_irq_enable);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      r            <= '0;
      r.tick_ratio <= SVPI_RATIO_RST;
      r.vector     <= SVPI_VECTOR;
    end
    else
    begin
      r <= n;
    end
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  assign o_call    = r.call;
  assign o_vector  = r.vector;
  assign o_push_pc = r.push_pc;
  assign o_wake    = r.wake;
  assign o_irq     = r.irq;
endmodule : svpi_top

// *** verilog/svpi_pkg.sv ***
// Shared constants for the shared-vector periodic interrupt group
package svpi_pkg;
  // ***********************************************************
  // Bus geometry
  // ***********************************************************
  localparam int          SVPI_ADDR_W    = 5;
  localparam logic [1:0]  SVPI_RESP_OKAY = 2'h0;
  localparam logic [1:0]  SVPI_RESP_SLV  = 2'h2;
  localparam logic [23:0] SVPI_RD_PAD    = 24'h000000;
  // ***********************************************************
  // Register byte offsets
  // ***********************************************************
  localparam logic [4:0] SVPI_OFF_CTRL  = 5'h00;
  localparam logic [4:0] SVPI_OFF_FLAGS = 5'h04;
  localparam logic [4:0] SVPI_OFF_TICK  = 5'h08;
  localparam logic [4:0] SVPI_OFF_ISTAT = 5'h0C;
  localparam logic [4:0] SVPI_OFF_IMASK = 5'h10;
  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int SVPI_CTRL_GIE   = 0;
  localparam int SVPI_CTRL_GRP   = 1;
  localparam int SVPI_CTRL_TICK  = 2;
  localparam int SVPI_CTRL_TB    = 3;
  localparam int SVPI_CTRL_T1    = 4;
  localparam int SVPI_FLG_SHARED = 0;
  localparam int SVPI_FLG_TICK   = 1;
  localparam int SVPI_FLG_TB     = 2;
  localparam int SVPI_FLG_T1     = 3;
  localparam int SVPI_EVT_N      = 4;
  // ***********************************************************
  // Reset values and timing
  // ***********************************************************
  localparam logic [2:0] SVPI_RATIO_RST   = 3'h7;
  localparam logic [7:0] SVPI_VECTOR      = 8'h18;
  localparam int         SVPI_CNT_W       = 15;
  localparam int         SVPI_TICK_EXP0   = 8;
  localparam int         SVPI_TB_EXP0     = 12;
  localparam logic [1:0] SVPI_SYS_DIV_END = 2'h3;
endpackage : svpi_pkg

// *** verilog/svpi_reg_if.sv ***
// Register access carrier between the bus slave and the register core
`timescale 1ns/10ps
interface svpi_reg_if;
  import svpi_pkg::*;
  logic                   wr_en;
  logic [SVPI_ADDR_W-1:0] wr_addr;
  logic [7:0]             wr_data;
  logic                   wr_be0;
  logic                   wr_hit;
  logic [SVPI_ADDR_W-1:0] rd_addr;
  logic [7:0]             rd_data;
  logic                   rd_hit;
  modport slave (output wr_en, wr_addr, wr_data, wr_be0, rd_addr,
                 input  wr_hit, rd_data, rd_hit);
  modport regs  (input  wr_en, wr_addr, wr_data, wr_be0, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface : svpi_reg_if

// *** verilog/svpi_periodic_div.sv ***
// Periodic source clock and the tick and time-base dividers
`timescale 1ns/10ps
module svpi_periodic_div
  import svpi_pkg::*;
#(
  parameter bit         FS_SEL_LOW_SPEED_INTERNAL_OSC = 1'b1,
  parameter logic [1:0] TB_SEL      = 2'h0
)(
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_low_speed_internal_osc_pulse,
  input  wire logic [2:0] i_ratio,
  output logic            o_tick_evt,
  output logic            o_tb_evt
);
  import svpi_pkg::*;

  typedef struct packed {
    logic [1:0]            prediv;
    logic [SVPI_CNT_W-1:0] cnt;
    logic                  tick;
    logic                  tb;
  } svpi_div_st_t;

  svpi_div_st_t             r;
  svpi_div_st_t             n;
  logic                     fs_pulse;
  logic [SVPI_CNT_W-1:0]    tick_mask;
  logic [SVPI_CNT_W-1:0]    tb_mask;

  // Source clock taken as a strobe so that everything stays on one clock
  assign fs_pulse = FS_SEL_LOW_SPEED_INTERNAL_OSC ? i_low_speed_internal_osc_pulse : (r.prediv == SVPI_SYS_DIV_END); // [RULE9]

  genvar gi;
  generate
    for (gi = 0; gi < SVPI_CNT_W; gi++)
    begin : g_mask
      assign tick_mask[gi] = (gi < (SVPI_TICK_EXP0 + int'(i_ratio))); // [RULE8]
      assign tb_mask[gi]   = (gi < (SVPI_TB_EXP0 + int'(TB_SEL)));    // [RULE12]
    end
  endgenerate

  always_comb
  begin
    n        = r;
    n.prediv = r.prediv + 2'h1;
    n.tick   = fs_pulse & ((r.cnt & tick_mask) == tick_mask);
    n.tb     = fs_pulse & ((r.cnt & tb_mask) == tb_mask);
    if (fs_pulse)
    begin
      n.cnt = r.cnt + {{(SVPI_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_tick_evt = r.tick;
  assign o_tb_evt   = r.tb;
endmodule : svpi_periodic_div

// *** verilog/svpi_axi_slave.sv ***
// AXI4-Lite slave front end for the interrupt group registers
`timescale 1ns/10ps
module svpi_axi_slave
  import svpi_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic                   i_awvalid,
  input  wire logic [SVPI_ADDR_W-1:0] i_awaddr,
  output logic                        o_awready,
  input  wire logic                   i_wvalid,
  input  wire logic [31:0]            i_wdata,
  input  wire logic [3:0]             i_wstrb,
  output logic                        o_wready,
  output logic                        o_bvalid,
  output logic [1:0]                  o_bresp,
  input  wire logic                   i_bready,
  input  wire logic                   i_arvalid,
  input  wire logic [SVPI_ADDR_W-1:0] i_araddr,
  output logic                        o_arready,
  output logic                        o_rvalid,
  output logic [31:0]                 o_rdata,
  output logic [1:0]                  o_rresp,
  input  wire logic                   i_rready,
  svpi_reg_if.slave                   bus
);
  import svpi_pkg::*;

  typedef struct packed {
    logic                   aw_have;
    logic                   w_have;
    logic [SVPI_ADDR_W-1:0] waddr;
    logic [7:0]             wdata;
    logic                   wbe0;
    logic                   awready;
    logic                   wready;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } svpi_axi_st_t;

  svpi_axi_st_t r;
  svpi_axi_st_t n;

  assign bus.wr_en   = r.aw_have & r.w_have & ~r.bvalid;
  assign bus.wr_addr = r.waddr;
  assign bus.wr_data = r.wdata;
  assign bus.wr_be0  = r.wbe0;
  assign bus.rd_addr = i_araddr;

  always_comb
  begin
    n = r;
    if (i_awvalid & r.awready)
    begin
      n.aw_have = 1'b1;
      n.waddr   = i_awaddr;
    end
    if (i_wvalid & r.wready)
    begin
      n.w_have = 1'b1;
      n.wdata  = i_wdata[7:0];
      n.wbe0   = i_wstrb[0];
    end
    if (bus.wr_en)
    begin
      n.bvalid  = 1'b1;
      n.bresp   = bus.wr_hit ? SVPI_RESP_OKAY : SVPI_RESP_SLV;
      n.aw_have = 1'b0;
      n.w_have  = 1'b0;
    end
    if (r.bvalid & i_bready)
    begin
      n.bvalid = 1'b0;
    end
    // Hold new writes off until the response has gone
    n.awready = ~n.aw_have & ~n.bvalid;
    n.wready  = ~n.w_have & ~n.bvalid;
    if (i_arvalid & r.arready)
    begin
      n.rvalid = 1'b1;
      n.rdata  = {SVPI_RD_PAD, bus.rd_data};
      n.rresp  = bus.rd_hit ? SVPI_RESP_OKAY : SVPI_RESP_SLV;
    end
    if (r.rvalid & i_rready)
    begin
      n.rvalid = 1'b0;
    end
    n.arready = ~n.rvalid;
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end

  assign o_awready = r.awready;
  assign o_wready  = r.wready;
  assign o_bvalid  = r.bvalid;
  assign o_bresp   = r.bresp;
  assign o_arready = r.arready;
  assign o_rvalid  = r.rvalid;
  assign o_rdata   = r.rdata;
  assign o_rresp   = r.rresp;
endmodule : svpi_axi_slave

// *** testbench/svpi_chk.sv ***
// Port-level assertions for the interrupt group
`timescale 1ns/10ps
module svpi_chk (
  input wire logic       i_clk_sys,
  input wire logic       i_reset,
  input wire logic       i_t2_strobe,
  input wire logic       i_stack_full,
  input wire logic       i_higher_pending,
  input wire logic       o_call,
  input wire logic       o_push_pc,
  input wire logic [7:0] o_vector,
  input wire logic       i_s_axi_awvalid,
  input wire logic       o_s_axi_awready,
  input wire logic       i_s_axi_wvalid,
  input wire logic       o_s_axi_wready,
  input wire logic       o_s_axi_bvalid,
  input wire logic       i_s_axi_arvalid,
  input wire logic       o_s_axi_arready,
  input wire logic       o_s_axi_rvalid
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);
  // *****************
  // Service entry
  // *****************
  a_vector_fixed: assert property (o_vector == svpi_pkg::SVPI_VECTOR)
    else $error("bad vector");
  a_call_with_push: assert property (o_call == o_push_pc)
    else $error("push mismatch");
  a_call_on_t2: assert property (o_call |-> $past(i_t2_strobe) &&
    !$past(i_stack_full) && !$past(i_higher_pending))
    else $error("call off T2");
  a_call_single: assert property (o_call |=> !o_call)
    else $error("double call");
  a_full_blocks: assert property (i_stack_full |=> !o_call)
    else $error("call while stack full");
  // *****************
  // Register bus
  // *****************
  a_aw_refused: assert property (i_s_axi_awvalid && o_s_axi_awready |=> !o_s_axi_awready)
    else $error("awready held");
  a_w_refused: assert property (i_s_axi_wvalid && o_s_axi_wready |=> !o_s_axi_wready)
    else $error("wready held");
  a_b_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
    o_s_axi_wready |-> ##[1:3] o_s_axi_bvalid)
    else $error("write response late");
  a_r_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |-> ##[1:2] o_s_axi_rvalid)
    else $error("read response late");
endmodule : svpi_chk

bind svpi_top svpi_chk i_chk (.*);

// *** testbench/svpi_core_model.sv ***
// Processor sequencer model: T2 slots, stack, entry count
`timescale 1ns/10ps
module svpi_core_model (
  input  wire logic i_clk_sys,
  input  wire logic i_reset,
  input  wire logic i_call,
  input  wire logic i_push_pc,
  input  wire logic i_full_cmd,
  input  wire logic i_higher_cmd,
  output logic      o_t2_strobe,
  output logic      o_stack_full,
  output logic      o_higher_pending,
  output int        o_n_calls
);
  logic [1:0] phase_r;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      phase_r   <= 2'h0;
      o_n_calls <= 0;
    end
    else
    begin
      phase_r <= phase_r + 2'h1;
      // Counts entries; service makes no nested calls
      if (i_call && i_push_pc)
        o_n_calls <= o_n_calls + 1;
    end
  end
  // T2 slot every fourth clock
  assign o_t2_strobe      = phase_r == 2'h3;
  // Stack full and rivals on scenario request
  assign o_stack_full     = i_full_cmd;
  assign o_higher_pending = i_higher_cmd;
endmodule : svpi_core_model

// *** testbench/tb.sv ***
// Self-checking bench for the interrupt group
`timescale 1ns/10ps
module tb;
  import svpi_pkg::*;
  logic i_clk_sys, i_reset, i_low_speed_internal_osc_pulse, i_timer1_overflow, full_cmd, higher_cmd;
  logic i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
  logic i_t2_strobe, i_stack_full, i_higher_pending, o_call, o_push_pc, o_wake, o_irq;
  logic [4:0]  i_s_axi_awaddr, i_s_axi_araddr;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
  logic [3:0]  i_s_axi_wstrb;
  logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
  logic [7:0]  o_vector;
  int          n_mismatch, n_compared, n_calls, n;
  logic [7:0]  pm [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h02};
  logic [7:0]  pr [5] = '{8'h00, 8'h01, 8'h02, 8'h07, 8'h00};
  int          pp [5] = '{256, 512, 1024, 32768, 4096};

  svpi_top #(.FS_SEL_LOW_SPEED_INTERNAL_OSC(1'b1), .TB_SEL(2'h0)) i_dut (.*);
  svpi_core_model i_core (.i_clk_sys, .i_reset, .i_call(o_call), .i_push_pc(o_push_pc),
    .i_full_cmd(full_cmd), .i_higher_cmd(higher_cmd), .o_t2_strobe(i_t2_strobe),
    .o_stack_full(i_stack_full), .o_higher_pending(i_higher_pending), .o_n_calls(n_calls));

  initial
  begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // *****************
  // Bus and check tasks
  // *****************
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
    n_compared++;
    if (act !== exp)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got %h exp %h", $time, act, exp);
    end
  endtask : cmp
  task automatic lim(input bit ok);
    if (!ok)
    begin
      n_mismatch++;
      stop_test();
    end
  endtask : lim
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge i_clk_sys);
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_awaddr  <= a;
    i_s_axi_wvalid  <= 1'b1;
    i_s_axi_wdata   <= 32'(d);
    i_s_axi_wstrb   <= s;
    i_s_axi_bready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      if (o_s_axi_awready)
        i_s_axi_awvalid <= 1'b0;
      if (o_s_axi_wready)
        i_s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!o_s_axi_bvalid && n < 50);
    lim(n < 50);
    cmp(o_s_axi_bresp, er);
    i_s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e,
                    input logic [1:0] er);
    @(posedge i_clk_sys);
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_araddr  <= a;
    i_s_axi_rready  <= 1'b1;
    n = 0;
    do
    begin
      @(posedge i_clk_sys);
      if (o_s_axi_arready)
        i_s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!o_s_axi_rvalid && n < 50);
    lim(n < 50);
    cmp(o_s_axi_rdata & {24'hFFFFFF, m}, {24'h000000, e});
    cmp(o_s_axi_rresp, er);
    i_s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wt(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 40000)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    lim(n < 40000);
  endtask : wt
  task automatic wcall(input int k);
    n = 0;
    while (n_calls != k && n < 5000)
    begin
      @(posedge i_clk_sys);
      n++;
    end
    cmp(n_calls, k);
  endtask : wcall
  task automatic ovf();
    @(posedge i_clk_sys);
    i_timer1_overflow <= 1'b1;
    @(posedge i_clk_sys);
    i_timer1_overflow <= 1'b0;
  endtask : ovf
  task automatic rise(output time t);
    wr(SVPI_OFF_ISTAT, 8'h0F, 4'hF, SVPI_RESP_OKAY);
    wt(o_irq, 1'b0);
    wt(o_irq, 1'b1);
    t = $time;
  endtask : rise
  task automatic per(input logic [7:0] m, input logic [7:0] r, input int p);
    time t0, t1;
    wr(SVPI_OFF_TICK, r, 4'hF, SVPI_RESP_OKAY);
    wr(SVPI_OFF_IMASK, m, 4'hF, SVPI_RESP_OKAY);
    rise(t0);
    rise(t1);
    cmp(32'((t1 - t0) / 10), p);
  endtask : per
  // *****************
  // Main sequence
  // *****************
  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    {i_reset, i_low_speed_internal_osc_pulse, i_timer1_overflow, full_cmd, higher_cmd} = 5'h18;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = 42'h00000000000;
    i_s_axi_wstrb = 4'hF;
    repeat (2) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    cmp(o_vector, SVPI_VECTOR);
    rd(SVPI_OFF_CTRL, 8'hFF, 8'h00, SVPI_RESP_OKAY);
    rd(SVPI_OFF_FLAGS, 8'hFF, 8'h00, SVPI_RESP_OKAY);
    rd(SVPI_OFF_TICK, 8'hFF, {5'h00, SVPI_RATIO_RST}, SVPI_RESP_OKAY);
    rd(SVPI_OFF_IMASK, 8'hFF, 8'h00, SVPI_RESP_OKAY);
    rd(5'h14, 8'hFF, 8'h00, SVPI_RESP_SLV);
    wr(5'h14, 8'hFF, 4'hF, SVPI_RESP_SLV);
    wr(SVPI_OFF_TICK, 8'h00, 4'hF, SVPI_RESP_OKAY);
    repeat (300) @(posedge i_clk_sys);
    rd(SVPI_OFF_FLAGS, 8'h03, 8'h02, SVPI_RESP_OKAY);
    cmp(n_calls, 0);
    cmp(o_wake, 1'b0);
    wr(SVPI_OFF_CTRL, 8'h13, 4'hE, SVPI_RESP_OKAY);
    rd(SVPI_OFF_CTRL, 8'hFF, 8'h00, SVPI_RESP_OKAY);
    wr(SVPI_OFF_CTRL, 8'h13, 4'hF, SVPI_RESP_OKAY);
    ovf();
    wcall(1);
    rd(SVPI_OFF_CTRL, 8'hFF, 8'h12, SVPI_RESP_OKAY);
    rd(SVPI_OFF_FLAGS, 8'h0B, 8'h0A, SVPI_RESP_OKAY);
    ovf();
    repeat (20) @(posedge i_clk_sys);
    cmp(n_calls, 1);
    rd(SVPI_OFF_FLAGS, 8'h01, 8'h01, SVPI_RESP_OKAY);
    full_cmd <= 1'b1;
    wr(SVPI_OFF_CTRL, 8'h13, 4'hF, SVPI_RESP_OKAY);
    repeat (20) @(posedge i_clk_sys);
    cmp(n_calls, 1);
    full_cmd   <= 1'b0;
    higher_cmd <= 1'b1;
    repeat (20) @(posedge i_clk_sys);
    cmp(n_calls, 1);
    higher_cmd <= 1'b0;
    wcall(2);
    wr(SVPI_OFF_CTRL, 8'h04, 4'hF, SVPI_RESP_OKAY);
    wt(o_wake, 1'b1);
    wr(SVPI_OFF_FLAGS, 8'h0F, 4'hF, SVPI_RESP_OKAY);
    wr(SVPI_OFF_CTRL, 8'h07, 4'hF, SVPI_RESP_OKAY);
    wcall(3);
    rd(SVPI_OFF_FLAGS, 8'h03, 8'h02, SVPI_RESP_OKAY);
    wr(SVPI_OFF_CTRL, 8'h0A, 4'hF, SVPI_RESP_OKAY);
    wr(SVPI_OFF_FLAGS, 8'h0F, 4'hF, SVPI_RESP_OKAY);
    wr(SVPI_OFF_CTRL, 8'h0B, 4'hF, SVPI_RESP_OKAY);
    wcall(4);
    rd(SVPI_OFF_FLAGS, 8'h05, 8'h04, SVPI_RESP_OKAY);
    wr(SVPI_OFF_IMASK, 8'h00, 4'hF, SVPI_RESP_OKAY);
    wr(SVPI_OFF_ISTAT, 8'h0F, 4'hF, SVPI_RESP_OKAY);
    repeat (300) @(posedge i_clk_sys);
    cmp(o_irq, 1'b0);
    rd(SVPI_OFF_ISTAT, 8'h01, 8'h01, SVPI_RESP_OKAY);
    foreach (pp[i])
      per(pm[i], pr[i], pp[i]);
    stop_test();
  end
endmodule : tb
